// file: rtl/scf_pkg.sv
// Constants, types and register map of the serial configuration front.
// Assumes a single 125 MHz core clock; every user writes scf_pkg::name.
package scf_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    // Register addresses of the serial register space.
    localparam logic [14:0] ADDR_IFACE_CFG = 15'h0000;
    localparam logic [14:0] ADDR_DEV_CFG = 15'h0002;
    localparam logic [14:0] ADDR_MAKER_LO = 15'h000c;
    localparam logic [14:0] ADDR_MAKER_HI = 15'h000d;
    localparam logic [14:0] ADDR_USER_SER = 15'h0010;
    localparam logic [14:0] ADDR_CLK_CTRL = 15'h0029;
    // One step of the streaming address.
    localparam logic [14:0] ADDR_STEP = 15'h0001;

    // Reset values.
    localparam logic [7:0] RST_IFACE_CFG = 8'h30;
    localparam logic [7:0] RST_DEV_CFG = 8'h00;
    localparam logic [7:0] RST_USER_SER = 8'h00;
    localparam logic [7:0] RST_CLK_CTRL = 8'h80;
    // Answer for an unmapped address.
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SOFT_RESET_BIT = 7;
    localparam int ASCEND_BIT = 5;
    localparam int ADDR_HOLD_BIT = 0;
    localparam int MODE_MSB = 1;
    localparam int MODE_LSB = 0;
    // Writable bits of the interface register; the reset bit never stores.
    localparam logic [7:0] IFACE_WR_MASK = 8'h6f;
    // Separate-output flag, always reads one.
    localparam logic [7:0] IFACE_FIXED_ONES = 8'h10;
    // Operating modes.
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_POWER_DOWN = 2'h3;

    // ------------------------------------------------------------
    // Serial framing and timing
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_LAST_BIT = 4'hf;
    localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
    localparam logic [3:0] BIT_ONE = 4'h1;
    localparam int CLK_MHZ = 125;
    localparam int RECOVERY_NS = 750;
    // Least time, so rounded up: 94 cycles.
    localparam int RECOVERY_CYC = (RECOVERY_NS * CLK_MHZ + 999) / 1000;
    localparam logic [6:0] RECOVERY_LOAD = 7'(RECOVERY_CYC - 1);
    localparam logic [6:0] CNT_ONE = 7'h01;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    // Command word: read flag then register address.
    typedef struct packed {
        logic rd;
        logic [14:0] addr;
    } scf_cmd_s;

    // Serial pins after synchronisation.
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic sdi;
    } scf_pins_s;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CMD = 4'b0010,
        ST_DATA = 4'b0100,
        ST_RECOVER = 4'b1000
    } scf_state_e;

endpackage : scf_pkg

// file: rtl/scf_pin_sync.sv
// Two-flop synchronisers for the serial pins, one per bit.
// Assumes the pins are asynchronous to i_core_clk.
`timescale 1ns/1ns
module scf_pin_sync #(
    parameter int W = 3,
    parameter logic [2:0] RST_VAL = 3'h0
) (
    // Clock, reset, enable.
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Pins in, synchronised levels out.
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    // ------------------------------------------------------------
    // Per-bit stages
    // ------------------------------------------------------------
    // The first stage feeds only the second; nothing else reads it.
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic meta_ff;
            logic sync_ff;
            always_ff @(posedge i_core_clk) begin
                if (i_rst) begin
                    meta_ff <= RST_VAL[g];
                    sync_ff <= RST_VAL[g];
                end else if (i_ce) begin
                    meta_ff <= i_async[g];
                    sync_ff <= meta_ff;
                end
            end
            assign o_sync[g] = sync_ff;
        end
    endgenerate

endmodule : scf_pin_sync

// file: rtl/scf_reg_front.sv
// Serial-configured front register group: soft reset, streaming
// address control, operating mode, maker code and first clock control.
// Assumes the serial pins are asynchronous and far slower than the core
// clock (at least four core cycles per serial clock half period).
`timescale 1ns/1ns
module scf_reg_front #(
    // Arbitrary neutral value for the maker code.
    parameter logic [15:0] MAKER_CODE = 16'h5a3c
) (
    // Clock, reset, enable.
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Serial port pins.
    input wire logic i_spi_sclk,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_sdi,
    output logic o_spi_sdo,
    // Controls to the rest of the chip.
    output logic o_chip_reset,
    output logic o_power_down,
    output logic [1:0] o_dev_mode,
    output logic [7:0] o_clock_control
);

    // ------------------------------------------------------------
    // Pin synchronisation and edges
    // ------------------------------------------------------------
    scf_pkg::scf_pins_s pins; // Synchronised pin levels.
    logic sclk_d_ff; // Serial clock one cycle later.
    logic cs_n_d_ff; // Select one cycle later.
    logic sclk_rise; // Sampling edge.
    logic sclk_fall; // Launch edge.
    logic cs_fall; // Start of a frame.

    // Select idles high, so it resets high.
    scf_pin_sync #(
        .W(3),
        .RST_VAL(3'h2)
    ) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_async({i_spi_sclk, i_spi_cs_n, i_spi_sdi}),
        .o_sync(pins)
    );

    // Delayed copies for edge detection.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            sclk_d_ff <= 1'b0;
            cs_n_d_ff <= 1'b1;
        end else if (i_ce) begin
            sclk_d_ff <= pins.sclk;
            cs_n_d_ff <= pins.cs_n;
        end
    end

    assign sclk_rise = pins.sclk & ~sclk_d_ff & ~pins.cs_n;
    assign sclk_fall = ~pins.sclk & sclk_d_ff & ~pins.cs_n;
    assign cs_fall = ~pins.cs_n & cs_n_d_ff;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    scf_pkg::scf_state_e state_ff; // Frame state.
    logic [3:0] bit_cnt_ff; // Bit within command or byte.
    logic [15:0] rx_sh_ff; // Incoming shift register.
    logic [15:0] nxt_rx_sh; // Shift register with the new bit.
    scf_pkg::scf_cmd_s cmd_ff; // Latched command.
    scf_pkg::scf_cmd_s nxt_cmd; // Command as it completes.
    logic [14:0] addr_ff; // Current register address.
    logic [14:0] nxt_addr; // Address for the next byte.
    logic [7:0] tx_sh_ff; // Outgoing byte.
    logic [6:0] rec_cnt_ff; // Recovery countdown.
    logic [7:0] iface_cfg_ff; // Interface configuration.
    logic [7:0] dev_cfg_ff; // Device operating configuration.
    logic [7:0] user_ser_ff; // User serial configuration.
    logic [7:0] clk_ctrl_ff; // First clock control.
    logic cmd_done; // Sixteenth command bit sampled.
    logic byte_done; // Eighth data bit sampled.
    logic wr_byte; // A data byte is to be stored.
    logic soft_hit; // Write that resets the chip.

    assign nxt_rx_sh = {rx_sh_ff[14:0], pins.sdi};
    assign nxt_cmd = scf_pkg::scf_cmd_s'(nxt_rx_sh);
    assign cmd_done = (state_ff == scf_pkg::ST_CMD) && sclk_rise &&
                      (bit_cnt_ff == scf_pkg::CMD_LAST_BIT);
    assign byte_done = (state_ff == scf_pkg::ST_DATA) && sclk_rise &&
                       (bit_cnt_ff == scf_pkg::BYTE_LAST_BIT);
    assign wr_byte = byte_done && !cmd_ff.rd;
    assign soft_hit = wr_byte && (addr_ff == scf_pkg::ADDR_IFACE_CFG) &&
                      nxt_rx_sh[scf_pkg::SOFT_RESET_BIT];

    // ------------------------------------------------------------
    // Address stepping
    // ------------------------------------------------------------
    // Hold wins over direction; the settings in force at the byte apply.
    always_comb begin
        if (user_ser_ff[scf_pkg::ADDR_HOLD_BIT]) begin
            nxt_addr = addr_ff;
        end else if (iface_cfg_ff[scf_pkg::ASCEND_BIT]) begin
            nxt_addr = addr_ff + scf_pkg::ADDR_STEP;
        end else begin
            nxt_addr = addr_ff - scf_pkg::ADDR_STEP;
        end
    end

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    // Register contents as seen by a read of the given address.
    function automatic logic [7:0] read_reg(input logic [14:0] a);
        logic [7:0] r;
        r = scf_pkg::RD_UNMAPPED;
        case (a)
            scf_pkg::ADDR_IFACE_CFG: begin
                r = iface_cfg_ff | scf_pkg::IFACE_FIXED_ONES;
            end
            scf_pkg::ADDR_DEV_CFG: r = dev_cfg_ff;
            scf_pkg::ADDR_MAKER_LO: r = MAKER_CODE[7:0];
            scf_pkg::ADDR_MAKER_HI: r = MAKER_CODE[15:8];
            scf_pkg::ADDR_USER_SER: r = user_ser_ff;
            scf_pkg::ADDR_CLK_CTRL: r = clk_ctrl_ff;
            default: r = scf_pkg::RD_UNMAPPED;
        endcase
        return r;
    endfunction : read_reg

    // ------------------------------------------------------------
    // Frame state machine
    // ------------------------------------------------------------
    // Raising select aborts a frame; during recovery the pins are ignored
    // and a frame already open is not joined halfway.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_ff <= scf_pkg::ST_IDLE;
            bit_cnt_ff <= 4'h0;
            rec_cnt_ff <= 7'h00;
        end else if (i_ce) begin
            case (state_ff)
                scf_pkg::ST_IDLE: begin
                    bit_cnt_ff <= 4'h0;
                    if (cs_fall) begin
                        state_ff <= scf_pkg::ST_CMD;
                    end
                end
                scf_pkg::ST_CMD, scf_pkg::ST_DATA: begin
                    if (soft_hit) begin
                        state_ff <= scf_pkg::ST_RECOVER;
                        rec_cnt_ff <= scf_pkg::RECOVERY_LOAD;
                    end else if (pins.cs_n) begin
                        state_ff <= scf_pkg::ST_IDLE;
                    end else if (cmd_done || byte_done) begin
                        state_ff <= scf_pkg::ST_DATA;
                        bit_cnt_ff <= 4'h0;
                    end else if (sclk_rise) begin
                        bit_cnt_ff <= bit_cnt_ff + scf_pkg::BIT_ONE;
                    end
                end
                scf_pkg::ST_RECOVER: begin
                    if (rec_cnt_ff == 7'h00) begin
                        state_ff <= scf_pkg::ST_IDLE;
                    end else begin
                        rec_cnt_ff <= rec_cnt_ff - scf_pkg::CNT_ONE;
                    end
                end
                default: begin
                    state_ff <= scf_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Shift in, command and address
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            rx_sh_ff <= 16'h0000;
            cmd_ff <= '0;
            addr_ff <= 15'h0000;
        end else if (i_ce) begin
            if (sclk_rise) begin
                rx_sh_ff <= nxt_rx_sh;
            end
            if (cmd_done) begin
                cmd_ff <= nxt_cmd;
                addr_ff <= nxt_cmd.addr;
            end else if (byte_done) begin
                addr_ff <= nxt_addr;
            end
        end
    end

    // ------------------------------------------------------------
    // Serial data out
    // ------------------------------------------------------------
    // Bytes load on the sampling edge and leave MSB first on the next
    // falling edge, so the host samples them on the rising edges after.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            tx_sh_ff <= 8'h00;
            o_spi_sdo <= 1'b0;
        end else if (i_ce) begin
            if (cmd_done) begin
                tx_sh_ff <= read_reg(nxt_cmd.addr);
            end else if (byte_done) begin
                tx_sh_ff <= read_reg(nxt_addr);
            end else if (sclk_fall && (state_ff == scf_pkg::ST_DATA)) begin
                // reads leave on the output pin
                o_spi_sdo <= cmd_ff.rd & tx_sh_ff[7];
                tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
            end
            if (pins.cs_n) begin
                o_spi_sdo <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    // A soft reset write restores every register, itself included, and
    // stores no part of its own data.
    always_ff @(posedge i_core_clk) begin
        if (i_rst || (i_ce && soft_hit)) begin
            iface_cfg_ff <= scf_pkg::RST_IFACE_CFG;
            dev_cfg_ff <= scf_pkg::RST_DEV_CFG;
            user_ser_ff <= scf_pkg::RST_USER_SER;
            clk_ctrl_ff <= scf_pkg::RST_CLK_CTRL;
        end else if (i_ce && wr_byte) begin
            case (addr_ff)
                scf_pkg::ADDR_IFACE_CFG: begin
                    iface_cfg_ff <= (nxt_rx_sh[7:0] & scf_pkg::IFACE_WR_MASK) |
                                    scf_pkg::IFACE_FIXED_ONES;
                end
                scf_pkg::ADDR_DEV_CFG: dev_cfg_ff <= nxt_rx_sh[7:0];
                scf_pkg::ADDR_USER_SER: user_ser_ff <= nxt_rx_sh[7:0];
                scf_pkg::ADDR_CLK_CTRL: clk_ctrl_ff <= nxt_rx_sh[7:0];
                // Maker code and unmapped addresses ignore writes.
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------
    // Registered once more so every output comes from its own flop.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_chip_reset <= 1'b0;
            o_power_down <= 1'b0;
            o_dev_mode <= scf_pkg::MODE_NORMAL;
            o_clock_control <= scf_pkg::RST_CLK_CTRL;
        end else if (i_ce) begin
            o_chip_reset <= soft_hit ||
                            ((state_ff == scf_pkg::ST_RECOVER) &&
                             (rec_cnt_ff != 7'h00));
            o_power_down <= (dev_cfg_ff[scf_pkg::MODE_MSB:scf_pkg::MODE_LSB]
                             == scf_pkg::MODE_POWER_DOWN);
            o_dev_mode <= dev_cfg_ff[scf_pkg::MODE_MSB:scf_pkg::MODE_LSB];
            o_clock_control <= clk_ctrl_ff;
        end
    end

endmodule : scf_reg_front

// file: sim/scf_reg_front_props.sv
// Checker for the serial configuration front, bound to its top.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ns
module scf_reg_front_props (
    // Clock, reset, enable.
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Serial pins.
    input wire logic i_spi_sclk,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_sdi,
    input wire logic o_spi_sdo,
    // Chip controls.
    input wire logic o_chip_reset,
    input wire logic o_power_down,
    input wire logic [1:0] o_dev_mode,
    input wire logic [7:0] o_clock_control
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    // Cycles the recovery pulse has stood; frozen with the enable.
    logic [7:0] recov_cnt_ff;
    always_ff @(posedge i_core_clk) begin
        if (i_rst || !o_chip_reset) begin
            recov_cnt_ff <= 8'h00;
        end else if (i_ce) begin
            recov_cnt_ff <= recov_cnt_ff + 8'h01;
        end
    end

    reset_values_a: assert property ($fell(i_rst) && $past(i_ce) |->
        o_clock_control == scf_pkg::RST_CLK_CTRL
        && o_dev_mode == scf_pkg::MODE_NORMAL
        && !o_chip_reset && !o_power_down && !o_spi_sdo)
        else $error("outputs wrong after reset");
    recov_len_a: assert property ($fell(o_chip_reset) |->
        recov_cnt_ff == 8'(scf_pkg::RECOVERY_CYC))
        else $error("recovery pulse length wrong");
    recov_bound_a: assert property (o_chip_reset |->
        recov_cnt_ff < 8'(scf_pkg::RECOVERY_CYC))
        else $error("recovery pulse too long");
    regs_cleared_a: assert property ($rose(o_chip_reset) |-> ##[0:1]
        (o_clock_control == scf_pkg::RST_CLK_CTRL
         && o_dev_mode == scf_pkg::MODE_NORMAL))
        else $error("soft reset left controls set");
    power_dn_on_a: assert property (o_dev_mode == 2'h3 |->
        ##[0:1] o_power_down) else $error("power down not raised");
    power_dn_off_a: assert property ((o_dev_mode != 2'h3) [*2] |->
        !o_power_down) else $error("power down without mode three");
    sdo_idle_a: assert property (i_spi_cs_n [*6] |-> !o_spi_sdo)
        else $error("serial output active while deselected");
    sdo_hold_a: assert property (i_spi_sclk [*4] |=>
        $stable(o_spi_sdo))
        else $error("serial output moved while clock high");
    idle_stable_a: assert property (i_spi_cs_n [*8] |=>
        $stable(o_clock_control) && $stable(o_dev_mode))
        else $error("controls changed outside a frame");

    // Main scenarios reached.
    cover property ($rose(o_chip_reset));
    cover property (o_power_down);
    cover property ($fell(o_spi_sdo));
endmodule : scf_reg_front_props

bind scf_reg_front scf_reg_front_props u_props (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_spi_sclk(i_spi_sclk), .i_spi_cs_n(i_spi_cs_n),
    .i_spi_sdi(i_spi_sdi), .o_spi_sdo(o_spi_sdo),
    .o_chip_reset(o_chip_reset), .o_power_down(o_power_down),
    .o_dev_mode(o_dev_mode), .o_clock_control(o_clock_control));

// file: sim/scf_spi_host.sv
// Serial host model: mode 0, command word then data, MSB first.
// Assumes the core clock paces it; half a serial period is HALF cycles.
`timescale 1ns/1ns
module scf_spi_host #(
    parameter int HALF = 6
) (
    // Pacing clock.
    input wire logic i_core_clk,
    // Serial pins.
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_sdi,
    input wire logic i_sdo
);
    // Idle: deselected, clock parked low.
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi = 1'b0;
    end

    task automatic half_wait();
        repeat (HALF) @(posedge i_core_clk);
    endtask : half_wait

    // One frame; data bytes come from the top of wd, read bytes land low.
    task automatic xfer(input logic rd, input logic [14:0] addr,
        input int n, input logic [23:0] wd, output logic [23:0] rq);
        logic [39:0] sh;
        sh = {rd, addr, wd};
        rq = 24'h000000;
        @(posedge i_core_clk);
        o_cs_n <= 1'b0;
        half_wait();
        for (int i = 0; i < 16 + 8 * n; i++) begin
            o_sclk <= 1'b0;
            o_sdi <= sh[39 - i];
            half_wait();
            o_sclk <= 1'b1;
            // Read data is taken at the rising edge.
            if (i >= 16) rq = {rq[22:0], i_sdo};
            half_wait();
        end
        o_sclk <= 1'b0;
        half_wait();
        // A released data line does not keep its last value.
        o_cs_n <= 1'b1;
        o_sdi <= ~o_sdi;
        half_wait();
    endtask : xfer
endmodule : scf_spi_host

// file: sim/tb_top.sv
// Self-checking bench for the serial configuration front.
// Assumes the host model paces frames well inside the pin sync limits.
`timescale 1ns/1ns
module tb_top;
    // Arbitrary neutral maker code for this run.
    localparam logic [15:0] MAKER = 16'h5a3c;
    typedef struct packed {
        logic wr;
        logic [14:0] a;
        logic [7:0] w;
        logic [7:0] e;
    } scf_row_s;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic ce = 1'b1;
    logic sclk, cs_n, sdi, sdo, chip_rst, pwr_dn;
    logic [1:0] mode;
    logic [7:0] clk_ctl;
    logic [23:0] v;
    int n_fail = 0;
    int cmp_count = 0;
    int rst_cyc = 0;
    int k;
    // Optional write, then a read that must give e.
    // reserved fields keep defaults
    scf_row_s rows [14] = '{
        '{1'b0, scf_pkg::ADDR_IFACE_CFG, 8'h00, 8'h30},
        '{1'b0, scf_pkg::ADDR_DEV_CFG, 8'h00, 8'h00},
        '{1'b0, scf_pkg::ADDR_USER_SER, 8'h00, 8'h00},
        '{1'b0, scf_pkg::ADDR_CLK_CTRL, 8'h00, 8'h80},
        '{1'b0, scf_pkg::ADDR_MAKER_LO, 8'h00, MAKER[7:0]},
        '{1'b1, scf_pkg::ADDR_MAKER_HI, 8'hff, MAKER[15:8]},
        '{1'b1, scf_pkg::ADDR_DEV_CFG, 8'h01, 8'h01},
        '{1'b1, scf_pkg::ADDR_DEV_CFG, 8'h02, 8'h02},
        '{1'b1, scf_pkg::ADDR_DEV_CFG, 8'h03, 8'h03},
        '{1'b1, scf_pkg::ADDR_DEV_CFG, 8'h00, 8'h00},
        '{1'b1, scf_pkg::ADDR_CLK_CTRL, 8'hd5, 8'hd5},
        '{1'b1, scf_pkg::ADDR_IFACE_CFG, 8'h00, 8'h10},
        '{1'b1, scf_pkg::ADDR_IFACE_CFG, 8'h20, 8'h30},
        '{1'b1, 15'h0005, 8'haa, 8'h00}};

    always #4 i_core_clk = ~i_core_clk;
    // Length of the soft reset recovery pulse.
    always @(posedge i_core_clk) begin
        if (chip_rst === 1'b1) rst_cyc <= rst_cyc + 1;
    end

    scf_reg_front #(.MAKER_CODE(MAKER)) DUT (.i_core_clk(i_core_clk),
        .i_rst(i_rst), .i_ce(ce), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n),
        .i_spi_sdi(sdi), .o_spi_sdo(sdo), .o_chip_reset(chip_rst),
        .o_power_down(pwr_dn), .o_dev_mode(mode), .o_clock_control(clk_ctl));
    scf_spi_host u_host (.i_core_clk(i_core_clk), .o_sclk(sclk),
        .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo));

    task check(input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task xf(input logic rd, input logic [14:0] a, input int n,
        input logic [23:0] wd);
        u_host.xfer(rd, a, n, wd, v);
    endtask : xf

    task summarize();
        $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    // Hang guard.
    initial begin
        #600000;
        n_fail++;
        summarize();
    end

    initial begin
        repeat (6) @(posedge i_core_clk);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        foreach (rows[i]) begin
            if (rows[i].wr) xf(1'b0, rows[i].a, 1, {rows[i].w, 16'h0000});
            xf(1'b1, rows[i].a, 1, 24'h000000);
            check(v[7:0], rows[i].e);
            if (rows[i].a == scf_pkg::ADDR_CLK_CTRL) begin
                check(clk_ctl, rows[i].e);
            end
            if (rows[i].a == scf_pkg::ADDR_DEV_CFG) begin
                check(mode, rows[i].e[1:0]);
                check(pwr_dn, rows[i].e[1:0] == 2'h3);
            end
        end
        // Ascending streams run across mapped and unmapped bytes.
        xf(1'b1, scf_pkg::ADDR_MAKER_LO, 3, 24'h000000);
        check(v, {MAKER[7:0], MAKER[15:8], 8'h00});
        xf(1'b0, 15'h0028, 2, 24'h11d900);
        check(clk_ctl, 8'hd9);
        // Enable low freezes the pin stages, so this frame is never seen.
        ce <= 1'b0;
        xf(1'b0, scf_pkg::ADDR_CLK_CTRL, 1, 24'h9a0000);
        ce <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        check(clk_ctl, 8'hd9);
        // Descending stream.
        xf(1'b0, scf_pkg::ADDR_IFACE_CFG, 1, 24'h000000);
        xf(1'b1, scf_pkg::ADDR_MAKER_HI, 3, 24'h000000);
        check(v, {MAKER[15:8], MAKER[7:0], 8'h00});
        // Address hold overrides the direction.
        xf(1'b0, scf_pkg::ADDR_USER_SER, 1, 24'h010000);
        xf(1'b1, scf_pkg::ADDR_MAKER_LO, 3, 24'h000000);
        check(v, {3{MAKER[7:0]}});
        xf(1'b0, scf_pkg::ADDR_CLK_CTRL, 2, 24'h818200);
        check(clk_ctl, 8'h82);
        xf(1'b0, scf_pkg::ADDR_USER_SER, 1, 24'h000000);
        xf(1'b0, scf_pkg::ADDR_IFACE_CFG, 1, 24'h200000);
        // Soft reset from power down.
        xf(1'b0, scf_pkg::ADDR_DEV_CFG, 1, 24'h030000);
        check(pwr_dn, 1'b1);
        xf(1'b0, scf_pkg::ADDR_IFACE_CFG, 1, 24'h800000);
        for (k = 0; k < 300 && chip_rst !== 1'b0; k++) @(posedge i_core_clk);
        if (k == 300) begin
            n_fail++;
        end else begin
            check(rst_cyc, scf_pkg::RECOVERY_CYC);
            xf(1'b1, scf_pkg::ADDR_IFACE_CFG, 3, 24'h000000);
            check(v, 24'h300000);
            check(clk_ctl, 8'h80);
            check(pwr_dn, 1'b0);
        end
        summarize();
    end
endmodule : tb_top
